// ==== rsel_host_model.sv ====
// Host side bus master issuing register cycles
`timescale 1ns/1ps
module rsel_host_model (
  input wire logic mclk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end
  // Request held until waitrequest is seen low; extra edge avoids re-entry in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !w;
    avs_write <= w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : xfer
endmodule : rsel_host_model

// ==== rsel_irq_select.sv ====
// Interrupt source selector with FIFO status flags and Avalon-MM register slave
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module rsel_irq_select
  import rsel_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] data_mode_field,
  input wire logic sync_event,
  input wire logic rssi_event,
  input wire logic queue_empty,
  input wire logic queue_full,
  input wire logic queue_threshold,
  input wire logic queue_overrun,
  input wire logic byte_written_event,
  input wire logic payload_ready_event,
  input wire logic address_match_event,
  input wire logic check_passed_event,
  input wire logic transmit_finished_event,
  input wire logic recovered_bit_clock,
  output logic queue_flush,
  output logic first_int_pin,
  output logic second_int_pin,
  output logic irq
);
  logic rst_meta;
  logic rst_sync_n;
  logic [1:0] first_pin_rx_source_sel;
  logic [1:0] second_pin_rx_source_sel;
  logic second_pin_tx_source_sel;
  logic queue_overrun_flag;
  logic [2:0] ctrl;
  logic [4:0] evt_status;
  logic [4:0] evt_mask;
  logic [4:0] evt_prev;
  rsel_bus_state_t bus_state;
  logic next_first_int_pin;
  logic next_second_int_pin;

  // Reset released through two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Accept on second cycle so read data comes from flops
  wire bus_req = avs_read | avs_write;
  wire bus_done = (bus_state == RSEL_BUS_ACK);
  assign avs_waitrequest = bus_req & ~bus_done;
  wire wr_lane0 = avs_write & bus_done & avs_byteenable[0];
  wire wr_cfg = wr_lane0 & (avs_address == RSEL_REG_FIFO_IRQ_SRC_CONFIG);
  wire wr_status = wr_lane0 & (avs_address == RSEL_REG_EVT_STATUS);
  wire wr_mask = wr_lane0 & (avs_address == RSEL_REG_EVT_MASK);
  wire wr_ctrl = wr_lane0 & (avs_address == RSEL_REG_CONTROL);
  wire rd_take = avs_read & ~bus_done;

  wire overrun_clear = wr_cfg & avs_writedata[RSEL_OVERRUN_BIT];
  wire transmitting = ctrl[RSEL_CTRL_TX_BIT];

  wire [7:0] cfg_view = {first_pin_rx_source_sel, second_pin_rx_source_sel, second_pin_tx_source_sel,
                         queue_full, ~queue_empty, queue_overrun_flag};

  wire [4:0] evt_now = {sync_event, payload_ready_event, transmit_finished_event, queue_full, queue_overrun};
  wire [4:0] evt_rise = evt_now & ~evt_prev;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_state <= RSEL_BUS_IDLE;
    end else begin
      case (bus_state)
        RSEL_BUS_IDLE: bus_state <= bus_req ? RSEL_BUS_ACK : RSEL_BUS_IDLE;
        RSEL_BUS_ACK: bus_state <= RSEL_BUS_IDLE;
        default: bus_state <= RSEL_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_take) begin
      case (avs_address)
        RSEL_REG_FIFO_IRQ_SRC_CONFIG: avs_readdata <= {24'h000000, cfg_view};
        RSEL_REG_EVT_STATUS: avs_readdata <= {27'h0000000, evt_status};
        RSEL_REG_EVT_MASK: avs_readdata <= {27'h0000000, evt_mask};
        RSEL_REG_CONTROL: avs_readdata <= {29'h00000000, ctrl};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // Full and nonempty bits are live views, so writes to them have nowhere to land
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      first_pin_rx_source_sel <= RSEL_CFG_RESET[7:6];
      second_pin_rx_source_sel <= RSEL_CFG_RESET[5:4];
      second_pin_tx_source_sel <= RSEL_CFG_RESET[3];
    end else if (wr_cfg) begin
      first_pin_rx_source_sel <= avs_writedata[RSEL_FIRST_SRC_LSB +: 2];
      second_pin_rx_source_sel <= avs_writedata[RSEL_SECOND_SRC_LSB +: 2];
      second_pin_tx_source_sel <= avs_writedata[RSEL_TX_SRC_BIT];
    end
  end

  // Overrun event wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      queue_overrun_flag <= 1'b0;
    end else if (queue_overrun) begin
      queue_overrun_flag <= 1'b1;
    end else if (overrun_clear) begin
      queue_overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      queue_flush <= 1'b0;
    end else begin
      queue_flush <= overrun_clear;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl <= RSEL_CTRL_RESET;
      evt_mask <= RSEL_MASK_RESET[4:0];
    end else begin
      if (wr_ctrl) ctrl <= avs_writedata[2:0];
      if (wr_mask) evt_mask <= avs_writedata[4:0];
    end
  end

  // Sticky event bits, write one to clear, set beats clear
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      evt_prev <= 5'h00;
      evt_status <= 5'h00;
    end else begin
      evt_prev <= evt_now;
      evt_status <= (evt_status & ~(wr_status ? avs_writedata[4:0] : 5'h00)) | evt_rise;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_mask);
    end
  end

  // Standby and receive share one selection; standby flag only informs software
  rsel_source_mux u_mux (
    .data_mode_field(data_mode_field),
    .transmitting(transmitting),
    .address_filter_on(ctrl[RSEL_CTRL_ADDR_FILT_BIT]),
    .first_pin_rx_source_sel(first_pin_rx_source_sel),
    .second_pin_rx_source_sel(second_pin_rx_source_sel),
    .second_pin_tx_source_sel(second_pin_tx_source_sel),
    .sync_event(sync_event),
    .rssi_event(rssi_event),
    .queue_empty(queue_empty),
    .queue_full(queue_full),
    .queue_threshold(queue_threshold),
    .byte_written_event(byte_written_event),
    .payload_ready_event(payload_ready_event),
    .address_match_event(address_match_event),
    .check_passed_event(check_passed_event),
    .transmit_finished_event(transmit_finished_event),
    .recovered_bit_clock(recovered_bit_clock),
    .next_first_int_pin(next_first_int_pin),
    .next_second_int_pin(next_second_int_pin)
  );

  // Pins registered: one cycle lag on every source, bit clock included
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      first_int_pin <= 1'b0;
      second_int_pin <= 1'b0;
    end else begin
      first_int_pin <= next_first_int_pin;
      second_int_pin <= next_second_int_pin;
    end
  end
endmodule : rsel_irq_select

// ==== rsel_irq_select_assertions.sv ====
// Concurrent checks on the interrupt source selector ports
`timescale 1ns/1ps
module rsel_irq_select_assertions (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] data_mode_field,
  input wire logic sync_event,
  input wire logic rssi_event,
  input wire logic queue_full,
  input wire logic queue_empty,
  input wire logic payload_ready_event,
  input wire logic recovered_bit_clock,
  input wire logic queue_flush,
  input wire logic first_int_pin,
  input wire logic second_int_pin
);
  logic [1:0] up;
  logic [7:0] cfg;
  wire wr_cfg = avs_write && !avs_waitrequest && avs_address == 8'h0D;
  wire rd_cfg = avs_read && !avs_waitrequest && avs_address == 8'h0D;
  wire first_sel = (cfg[7:6] == 2'h1) ? rssi_event : sync_event;
  // Shadow of the source fields; skip cycles while the internal reset drains
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      up <= 2'h0;
      cfg <= 8'h00;
    end else begin
      if (up != 2'h3) up <= up + 2'h1;
      if (wr_cfg) cfg <= avs_writedata[7:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n || up != 2'h3);
  chk_wait_one: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait cycle");
  chk_flush_pulse: assert property (wr_cfg && avs_writedata[0] |=> queue_flush ##1 !queue_flush)
    else $error("flush pulse missing");
  chk_flush_cause: assert property (queue_flush |-> $past(wr_cfg && avs_writedata[0]))
    else $error("flush without clearing write");
  chk_rd_flags: assert property (rd_cfg |-> avs_readdata[2:1] == {$past(queue_full), !$past(queue_empty)})
    else $error("live flags wrong");
  chk_cont_clock: assert property (data_mode_field == 2'h0 |=> second_int_pin == $past(recovered_bit_clock))
    else $error("second pin not bit clock");
  chk_cont_first: assert property (data_mode_field == 2'h0 |=> first_int_pin == $past(first_sel))
    else $error("first pin wrong in continuous mode");
  chk_buf_full: assert property (data_mode_field == 2'h1 && cfg[5:3] == 3'h2 |=> second_int_pin == $past(queue_full))
    else $error("second pin not full flag");
  chk_pkt_payload: assert property (data_mode_field[1] && cfg[7:6] == 2'h0 |=> first_int_pin == $past(payload_ready_event))
    else $error("first pin not payload ready");
  cover property (queue_flush);
  cover property (rd_cfg);
  cover property (data_mode_field == 2'h0 && recovered_bit_clock);
endmodule : rsel_irq_select_assertions
bind rsel_irq_select rsel_irq_select_assertions u_chk (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .data_mode_field(data_mode_field), .sync_event(sync_event),
  .rssi_event(rssi_event), .queue_full(queue_full), .queue_empty(queue_empty),
  .payload_ready_event(payload_ready_event), .recovered_bit_clock(recovered_bit_clock),
  .queue_flush(queue_flush), .first_int_pin(first_int_pin), .second_int_pin(second_int_pin));

// ==== rsel_irq_select_test.sv ====
// Self-checking bench for the interrupt source selector
`timescale 1ns/1ps
module rsel_irq_select_test
  import rsel_pkg::*;
;
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] cfg;
    logic [2:0] ctrl;
    logic [11:0] ev;
    logic [1:0] pins;
  } rsel_row_t;
  // Event order: sync rssi empty full thr ovr byte payload match crc done clock
  rsel_row_t rows [16] = '{
    '{2'h0, 8'hC0, 3'h0, 12'h001, 2'h2}, '{2'h0, 8'h80, 3'h0, 12'h801, 2'h3},
    '{2'h0, 8'h40, 3'h0, 12'h002, 2'h2}, '{2'h0, 8'h30, 3'h0, 12'h011, 2'h2},
    '{2'h1, 8'hC0, 3'h0, 12'hFDF, 2'h2}, '{2'h1, 8'hB0, 3'h0, 12'h014, 2'h3},
    '{2'h1, 8'h60, 3'h0, 12'h042, 2'h3}, '{2'h1, 8'h10, 3'h0, 12'hFDF, 2'h1},
    '{2'h1, 8'h08, 3'h1, 12'h400, 2'h1}, '{2'h1, 8'h00, 3'h1, 12'h008, 2'h1},
    '{2'h2, 8'hC0, 3'h0, 12'h001, 2'h2}, '{2'h2, 8'hC0, 3'h2, 12'h300, 2'h3},
    '{2'h3, 8'h00, 3'h0, 12'h280, 2'h3}, '{2'h2, 8'h08, 3'h1, 12'h400, 2'h1},
    '{2'h0, 8'h08, 3'h1, 12'h800, 2'h1}, '{2'h1, 8'h90, 3'h4, 12'h00C, 2'h3}};
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [11:0] ev = 12'h004;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic first_int_pin;
  logic second_int_pin;
  logic irq;
  logic queue_flush;
  int fails = 0;
  int total_checks = 0;
  int flushes = 0;
  always #10 mclk = ~mclk;
  // Counts flush pulses so a missing or doubled pulse is seen
  always @(posedge mclk) begin
    if (queue_flush === 1'b1) flushes++;
  end
  rsel_host_model u_rsel_host_model (.mclk(mclk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable));
  rsel_irq_select u_rsel_irq_select (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .data_mode_field(mode),
    .sync_event(ev[0]), .rssi_event(ev[1]), .queue_empty(ev[2]), .queue_full(ev[3]), .queue_threshold(ev[4]),
    .queue_overrun(ev[5]), .byte_written_event(ev[6]), .payload_ready_event(ev[7]), .address_match_event(ev[8]),
    .check_passed_event(ev[9]), .transmit_finished_event(ev[10]), .recovered_bit_clock(ev[11]),
    .queue_flush(queue_flush), .first_int_pin(first_int_pin), .second_int_pin(second_int_pin), .irq(irq));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] q;
    u_rsel_host_model.xfer(1'b0, a, 8'h00, q);
    chk(what, exp, q);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_rsel_host_model.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(RSEL_REG_FIFO_IRQ_SRC_CONFIG, RSEL_CFG_RESET, "config reset");
    rd(RSEL_REG_EVT_MASK, RSEL_MASK_RESET, "mask reset");
    rd(RSEL_REG_CONTROL, 8'h00, "control reset");
    rd(8'h20, 8'h00, "unmapped");
    $display("reset test done");
    foreach (rows[i]) begin
      wr(RSEL_REG_FIFO_IRQ_SRC_CONFIG, rows[i].cfg);
      wr(RSEL_REG_CONTROL, {5'h00, rows[i].ctrl});
      mode <= rows[i].mode;
      ev <= rows[i].ev;
      repeat (2) @(posedge mclk);
      chk("pins", {6'h00, rows[i].pins}, {6'h00, first_int_pin, second_int_pin});
      rd(RSEL_REG_FIFO_IRQ_SRC_CONFIG, {rows[i].cfg[7:3], rows[i].ev[3], !rows[i].ev[2], 1'b0}, "flags");
    end
    $display("table test done");
    mode <= 2'h1;
    ev <= 12'h004;
    wr(RSEL_REG_FIFO_IRQ_SRC_CONFIG, 8'hFE);
    rd(RSEL_REG_FIFO_IRQ_SRC_CONFIG, 8'hF8, "status write");
    ev <= 12'h024;
    @(posedge mclk);
    ev <= 12'h004;
    rd(RSEL_REG_FIFO_IRQ_SRC_CONFIG, 8'hF9, "overrun set");
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(RSEL_REG_EVT_MASK, 8'h01);
    @(posedge mclk);
    chk("irq", 8'h01, {7'h00, irq});
    wr(RSEL_REG_FIFO_IRQ_SRC_CONFIG, 8'hF9);
    rd(RSEL_REG_FIFO_IRQ_SRC_CONFIG, 8'hF8, "overrun clear");
    chk("flush pulses", 8'h01, flushes[7:0]);
    wr(RSEL_REG_EVT_STATUS, 8'h01);
    @(posedge mclk);
    chk("irq clear", 8'h00, {7'h00, irq});
    $display("overrun test done");
    summarize();
  end
endmodule : rsel_irq_select_test

// ==== rsel_pkg.sv ====
// Constants and types for the radio interrupt source selector
package rsel_pkg;
  localparam logic [7:0] RSEL_REG_FIFO_IRQ_SRC_CONFIG = 8'h0D;
  localparam logic [7:0] RSEL_REG_EVT_STATUS = 8'h10;
  localparam logic [7:0] RSEL_REG_EVT_MASK = 8'h11;
  localparam logic [7:0] RSEL_REG_CONTROL = 8'h12;
  localparam logic [7:0] RSEL_CFG_RESET = 8'h00;
  localparam logic [7:0] RSEL_MASK_RESET = 8'h00;
  localparam logic [2:0] RSEL_CTRL_RESET = 3'h0;
  localparam int RSEL_FIRST_SRC_LSB = 6;
  localparam int RSEL_SECOND_SRC_LSB = 4;
  localparam int RSEL_TX_SRC_BIT = 3;
  localparam int RSEL_FULL_BIT = 2;
  localparam int RSEL_NONEMPTY_BIT = 1;
  localparam int RSEL_OVERRUN_BIT = 0;
  localparam int RSEL_CTRL_TX_BIT = 0;
  localparam int RSEL_CTRL_ADDR_FILT_BIT = 1;
  localparam int RSEL_CTRL_STANDBY_BIT = 2;
  localparam int RSEL_EVT_OVERRUN = 0;
  localparam int RSEL_EVT_FULL = 1;
  localparam int RSEL_EVT_TX_DONE = 2;
  localparam int RSEL_EVT_PAYLOAD = 3;
  localparam int RSEL_EVT_SYNC = 4;
  localparam logic [1:0] RSEL_MODE_CONT = 2'h0;
  localparam logic [1:0] RSEL_MODE_BUF = 2'h1;
  typedef enum logic [1:0] {
    RSEL_BUS_IDLE = 2'b00,
    RSEL_BUS_ACK = 2'b01
  } rsel_bus_state_t;
endpackage : rsel_pkg

// ==== rsel_source_mux.sv ====
// Mode dependent source selection for both interrupt request pins
`timescale 1ns/1ps
module rsel_source_mux
  import rsel_pkg::*;
(
  input wire logic [1:0] data_mode_field,
  input wire logic transmitting,
  input wire logic address_filter_on,
  input wire logic [1:0] first_pin_rx_source_sel,
  input wire logic [1:0] second_pin_rx_source_sel,
  input wire logic second_pin_tx_source_sel,
  input wire logic sync_event,
  input wire logic rssi_event,
  input wire logic queue_empty,
  input wire logic queue_full,
  input wire logic queue_threshold,
  input wire logic byte_written_event,
  input wire logic payload_ready_event,
  input wire logic address_match_event,
  input wire logic check_passed_event,
  input wire logic transmit_finished_event,
  input wire logic recovered_bit_clock,
  output logic next_first_int_pin,
  output logic next_second_int_pin
);
  wire cont_mode = (data_mode_field == RSEL_MODE_CONT);
  wire buf_mode = (data_mode_field == RSEL_MODE_BUF);
  wire pkt_sync = address_filter_on ? address_match_event : sync_event;

  always_comb begin
    next_first_int_pin = 1'b0;
    if (cont_mode) begin
      next_first_int_pin = (first_pin_rx_source_sel == 2'h1) ? rssi_event : sync_event;
    end else begin
      case (first_pin_rx_source_sel)
        2'h3: next_first_int_pin = buf_mode ? sync_event : pkt_sync;
        2'h2: next_first_int_pin = queue_empty;
        2'h1: next_first_int_pin = byte_written_event;
        default: next_first_int_pin = buf_mode ? 1'b0 : payload_ready_event;
      endcase
    end
  end

  always_comb begin
    next_second_int_pin = 1'b0;
    if (cont_mode) begin
      next_second_int_pin = recovered_bit_clock;
    end else if (transmitting) begin
      next_second_int_pin = second_pin_tx_source_sel ? transmit_finished_event : queue_full;
    end else begin
      case (second_pin_rx_source_sel)
        2'h3: next_second_int_pin = queue_threshold;
        2'h2: next_second_int_pin = rssi_event;
        2'h1: next_second_int_pin = queue_full;
        default: next_second_int_pin = buf_mode ? 1'b0 : check_passed_event;
      endcase
    end
  end
endmodule : rsel_source_mux
